// ===== design/sfg_guard.sv
`timescale 1ns/1ps
`default_nettype none
module sfg_guard #(
    parameter int RETRY_FAST_CYC = sfg_pkg::RETRY_FAST_US * 1000 / sfg_pkg::CLK_NS,
    parameter int RETRY_SLOW_CYC = sfg_pkg::RETRY_SLOW_US * 1000 / sfg_pkg::CLK_NS,
    parameter int SLOW_TICK_CYC = sfg_pkg::SLOW_TICK_US * 1000 / sfg_pkg::CLK_NS
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic cfg_wr_en_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wdata_in,
    output logic [7:0] cfg_rdata_out,
    // Stage two sense
    input wire logic stage2_gate_drive_in,
    input wire logic aux_winding_feedback_in,
    input wire logic stage2_current_sense_in,
    input wire logic stage2_sense_min_in,
    // Thermal sense
    input wire logic ntc_above_ref_in,
    input wire logic die_over_limit_in,
    input wire logic die_resume_in,
    input wire logic half_line_in,
    // Protection outputs
    output logic stage2_off_out,
    output logic stages_power_en_out,
    output logic fault_active_out,
    output logic fault_latched_out,
    output logic [2:0] fault_cause_out,
    output logic fault_off_behaviour_out,
    // Thermal outputs
    output logic [7:0] ntc_code_out,
    output logic external_thermal_guard_out,
    output logic die_thermal_guard_out,
    output logic [7:0] dim_scale_out
);
    // Whole block state
    typedef struct packed {
        logic [sfg_pkg::NREG-1:0][7:0] regs; // Configuration
        logic [7:0] rdata; // Read data
        logic [5:0] s1; // First sync stage
        logic [5:0] s2; // Second sync stage
        logic gate_q; // Gate drive, last cycle
        logic [7:0] ph; // Cycles since gate edge
        logic ov_hit; // Overvoltage seen this off time
        logic oc_hit; // Overcurrent seen this on time
        logic ol_hit; // Sense reached minimum in scan
        logic ol_done; // Scan finished this on time
        logic [2:0] ov_acc; // Event counts
        logic [2:0] oc_acc;
        logic [2:0] ol_acc;
        sfg_pkg::sfg_flt_e fst; // Fault supervisor
        logic fact; // Fault active
        logic [2:0] cause; // Open-loop, overcurrent, overvoltage
        logic [19:0] unit_cnt; // Retry unit timer
        logic [5:0] retry_cnt; // Retry units done
        logic [7:0] code; // Thermistor code
        logic [2:0] half_cnt; // Half line-cycles seen
        logic [7:0] trk_cnt; // Start-up step timer
        logic [7:0] steps; // Start-up steps done
        logic boot; // Start-up tracking
        logic started; // Stages powered
        logic [23:0] fast_acc; // Fast filter
        logic [23:0] slow_acc; // Slow filter
        logic [9:0] fast_tick;
        logic [16:0] slow_tick;
        logic ext_hot; // External overheat
        logic die_hot; // Die overheat
        logic [7:0] dim; // Dim scale
        logic off; // Stage two stopped
    } sfg_state_s;

    sfg_state_s st_reg; // Registered state
    sfg_state_s st_next; // Next state

    // Saturating event count step, floors at zero
    function automatic logic [2:0] acc_step(input logic [2:0] acc, input logic up);
        if (up) begin
            acc_step = (acc == 3'h7) ? acc : acc + 3'h1;
        end else begin
            acc_step = (acc == 3'h0) ? acc : acc - 3'h1;
        end
    endfunction

    // One step of a first-order low-pass, 16 fraction bits
    function automatic logic [23:0] iir(input logic [23:0] acc, input logic [7:0] code,
                                        input logic [3:0] sh);
        logic signed [24:0] d;
        d = $signed({1'b0, code, 16'h0000}) - $signed({1'b0, acc});
        iir = acc + 24'(d >>> sh);
    endfunction

    // Register index for an address, all ones when unmapped
    function automatic logic [3:0] reg_idx(input logic [7:0] a);
        reg_idx = 4'hF;
        for (int i = 0; i < sfg_pkg::NREG; i++) begin
            if (a == sfg_pkg::REG_OFS[i]) begin
                reg_idx = 4'(i);
            end
        end
    endfunction

    // Configuration fields
    logic dov, doc, dol; // Guard disables
    logic lov, loc, lol; // Latch selects
    logic [2:0] tov, toc, tol; // Count thresholds
    logic [7:0] bov, boc, bol; // Blanking in cycles
    logic [7:0] wake_code, cut_code; // Thermal codes
    logic [19:0] unit_last; // Retry unit length minus one
    assign dov = st_reg.regs[sfg_pkg::IX_DIS][sfg_pkg::B_OV_DIS];
    assign doc = st_reg.regs[sfg_pkg::IX_DIS][sfg_pkg::B_OC_DIS];
    assign dol = st_reg.regs[sfg_pkg::IX_DIS][sfg_pkg::B_OL_DIS];
    assign lov = st_reg.regs[sfg_pkg::IX_AUX][sfg_pkg::B_OV_LAT];
    assign loc = st_reg.regs[sfg_pkg::IX_CNT][sfg_pkg::B_OC_LAT];
    assign lol = st_reg.regs[sfg_pkg::IX_CNT][sfg_pkg::B_OL_LAT];
    assign tov = st_reg.regs[sfg_pkg::IX_AUX][sfg_pkg::F_OV_CNT +: 3];
    assign toc = st_reg.regs[sfg_pkg::IX_CNT][sfg_pkg::F_OC_CNT +: 3];
    assign tol = st_reg.regs[sfg_pkg::IX_CNT][sfg_pkg::F_OL_CNT +: 3];
    // Blanking style doubles the overvoltage window
    assign bov = 8'(st_reg.regs[sfg_pkg::IX_AUX][sfg_pkg::F_OV_BLANK +: 3]
        * sfg_pkg::BLANK_UNIT_CYC) << st_reg.regs[sfg_pkg::IX_AUX][sfg_pkg::B_OV_STYLE];
    assign boc = 8'(st_reg.regs[sfg_pkg::IX_BLANK][sfg_pkg::F_OC_BLANK +: 3]
        * sfg_pkg::BLANK_UNIT_CYC);
    assign bol = 8'(st_reg.regs[sfg_pkg::IX_BLANK][sfg_pkg::F_OL_BLANK +: 3]
        * sfg_pkg::BLANK_UNIT_CYC);
    // Four-bit set points sit in the code's upper nibble
    assign wake_code = {st_reg.regs[sfg_pkg::IX_RESUME][3:0], 4'h0};
    assign cut_code = {st_reg.regs[sfg_pkg::IX_CUTOFF][3:0], 4'h0};
    assign unit_last = st_reg.regs[sfg_pkg::IX_RETRY][sfg_pkg::B_SLOW]
        ? 20'(RETRY_SLOW_CYC - 1) : 20'(RETRY_FAST_CYC - 1);

    // Next-state logic
    always_comb begin
        logic rise, fall, run, step, ovf, ocf, olf, ol_end;
        logic [7:0] fc, sc;
        logic [9:0] ex;
        logic [3:0] wi;
        rise = 1'b0;
        fall = 1'b0;
        run = 1'b0;
        step = 1'b0;
        ovf = 1'b0;
        ocf = 1'b0;
        olf = 1'b0;
        ol_end = 1'b0;
        fc = 8'h00;
        sc = 8'h00;
        ex = 10'h000;
        wi = 4'h0;
        st_next = st_reg;
        // Comparator and pin synchronisers
        st_next.s1 = {die_resume_in, die_over_limit_in, ntc_above_ref_in,
                      stage2_sense_min_in, stage2_current_sense_in, aux_winding_feedback_in};
        st_next.s2 = st_reg.s1;
        // Gate edges and phase timer
        st_next.gate_q = stage2_gate_drive_in;
        rise = stage2_gate_drive_in & ~st_reg.gate_q;
        fall = ~stage2_gate_drive_in & st_reg.gate_q;
        if (rise | fall) begin
            st_next.ph = 8'h00;
        end else if (st_reg.ph != 8'hFF) begin
            st_next.ph = st_reg.ph + 8'h01;
        end
        run = (st_reg.fst == sfg_pkg::FLT_RUN);
        if (!st_reg.gate_q && st_reg.ph >= bov && st_reg.s2[sfg_pkg::S_OV]) begin
            st_next.ov_hit = 1'b1;
        end
        if (rise) begin
            st_next.ov_hit = 1'b0;
            if (run) begin
                st_next.ov_acc = acc_step(st_reg.ov_acc, st_reg.ov_hit);
            end
        end
        if (st_reg.gate_q && st_reg.ph >= boc && st_reg.s2[sfg_pkg::S_OC]) begin
            st_next.oc_hit = 1'b1;
        end
        if (fall) begin
            st_next.oc_hit = 1'b0;
            if (run) begin
                st_next.oc_acc = acc_step(st_reg.oc_acc, st_reg.oc_hit);
            end
        end
        if (st_reg.gate_q && !st_reg.ol_done && st_reg.ph >= bol) begin
            if (st_reg.s2[sfg_pkg::S_OL]) begin
                st_next.ol_hit = 1'b1;
            end
            ol_end = (st_reg.ph == bol + 8'(sfg_pkg::OL_SCAN_CYC - 1));
        end
        // Gate dropping early also ends the scan
        if (ol_end || (fall && !st_reg.ol_done)) begin
            st_next.ol_done = 1'b1;
            if (run) begin
                st_next.ol_acc = acc_step(st_reg.ol_acc, !st_next.ol_hit);
            end
        end
        if (rise) begin
            st_next.ol_done = 1'b0;
            st_next.ol_hit = 1'b0;
        end
        if (dov) begin
            st_next.ov_acc = 3'h0;
        end
        if (doc) begin
            st_next.oc_acc = 3'h0;
        end
        if (dol) begin
            st_next.ol_acc = 3'h0;
        end
        ovf = !dov && st_reg.ov_acc >= tov;
        ocf = !doc && st_reg.oc_acc >= toc;
        olf = !dol && st_reg.ol_acc >= tol;
        // Fault supervisor
        case (st_reg.fst)
            sfg_pkg::FLT_RUN: begin
                if (ovf | ocf | olf) begin
                    st_next.fact = 1'b1;
                    st_next.cause = {olf, ocf, ovf};
                    st_next.unit_cnt = 20'h00000;
                    st_next.retry_cnt = 6'h00;
                    if ((ovf & lov) | (ocf & loc) | (olf & lol)) begin
                        st_next.fst = sfg_pkg::FLT_LATCH;
                    end else begin
                        st_next.fst = sfg_pkg::FLT_HOLD;
                    end
                end
            end
            sfg_pkg::FLT_HOLD: begin
                // Retry delay is one more unit than programmed
                if (st_reg.unit_cnt == unit_last) begin
                    st_next.unit_cnt = 20'h00000;
                    if (st_reg.retry_cnt == st_reg.regs[sfg_pkg::IX_RETRY][5:0]) begin
                        st_next.fst = sfg_pkg::FLT_RUN;
                        st_next.fact = 1'b0;
                        st_next.cause = 3'h0;
                        st_next.ov_acc = 3'h0;
                        st_next.oc_acc = 3'h0;
                        st_next.ol_acc = 3'h0;
                    end else begin
                        st_next.retry_cnt = st_reg.retry_cnt + 6'h01;
                    end
                end else begin
                    st_next.unit_cnt = st_reg.unit_cnt + 20'h00001;
                end
            end
            sfg_pkg::FLT_LATCH: begin
                // Held until power is cycled
                st_next.fst = sfg_pkg::FLT_LATCH;
            end
            default: begin
                st_next.fst = sfg_pkg::FLT_LATCH;
            end
        endcase
        if (st_reg.boot) begin
            if (st_reg.trk_cnt == 8'(sfg_pkg::BOOT_STEP_CYC - 1)) begin
                st_next.trk_cnt = 8'h00;
                step = 1'b1;
                st_next.steps = st_reg.steps + 8'h01;
                if (st_reg.steps == 8'hFF) begin
                    st_next.boot = 1'b0;
                end
            end else begin
                st_next.trk_cnt = st_reg.trk_cnt + 8'h01;
            end
        end else if (half_line_in) begin
            if (st_reg.half_cnt == sfg_pkg::HALF_LINE_LAST) begin
                st_next.half_cnt = 3'h0;
                step = 1'b1;
            end else begin
                st_next.half_cnt = st_reg.half_cnt + 3'h1;
            end
        end
        if (step) begin
            if (st_reg.s2[sfg_pkg::S_NTC]) begin
                st_next.code = (st_reg.code == 8'h00) ? st_reg.code : st_reg.code - 8'h01;
            end else begin
                st_next.code = (st_reg.code == 8'hFF) ? st_reg.code : st_reg.code + 8'h01;
            end
        end
        // Filters track the raw code during start-up
        if (st_reg.boot) begin
            st_next.fast_acc = {st_reg.code, 16'h0000};
            st_next.slow_acc = {st_reg.code, 16'h0000};
        end else begin
            st_next.fast_tick = st_reg.fast_tick + 10'h001;
            if (st_reg.fast_tick == 10'(sfg_pkg::FAST_TICK_CYC - 1)) begin
                st_next.fast_tick = 10'h000;
                st_next.fast_acc = iir(st_reg.fast_acc, st_reg.code,
                    {1'b0, st_reg.regs[sfg_pkg::IX_FILT][sfg_pkg::F_FAST_TC +: 3]} + 4'h1);
            end
            st_next.slow_tick = st_reg.slow_tick + 17'h00001;
            if (st_reg.slow_tick == 17'(SLOW_TICK_CYC - 1)) begin
                st_next.slow_tick = 17'h00000;
                st_next.slow_acc = iir(st_reg.slow_acc, st_reg.code,
                    {1'b0, st_reg.regs[sfg_pkg::IX_FILT][sfg_pkg::F_SLOW_TC +: 3]} + 4'h7);
            end
        end
        fc = st_reg.fast_acc[23:16];
        sc = st_reg.slow_acc[23:16];
        // hotter is larger, cutoff sets overheat
        if (fc > cut_code) begin
            st_next.ext_hot = 1'b1;
        end else if (fc < wake_code) begin
            st_next.ext_hot = 1'b0;
        end
        if (!st_reg.boot && fc < wake_code) begin
            st_next.started = 1'b1;
        end
        // die overheat with hysteresis, set wins
        if (st_reg.s2[sfg_pkg::S_DHI]) begin
            st_next.die_hot = 1'b1;
        end else if (st_reg.s2[sfg_pkg::S_DLO]) begin
            st_next.die_hot = 1'b0;
        end
        if (sc > st_reg.regs[sfg_pkg::IX_DERATE]) begin
            ex = {2'b00, sc - st_reg.regs[sfg_pkg::IX_DERATE]}
                << st_reg.regs[sfg_pkg::IX_SLOPE][1:0];
            st_next.dim = (ex > 10'h0FF) ? 8'h00 : 8'hFF - ex[7:0];
        end else begin
            st_next.dim = 8'hFF;
        end
        // Stage two stop
        st_next.off = !st_next.started | st_next.die_hot | st_next.ext_hot | st_next.fact;
        // Register write and read
        wi = reg_idx(cfg_addr_in);
        if (cfg_wr_en_in && wi != 4'hF) begin
            st_next.regs[wi] = cfg_wdata_in;
        end
        st_next.rdata = (wi == 4'hF) ? 8'h00 : st_reg.regs[wi];
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
            st_reg.regs <= sfg_pkg::REG_RST;
            st_reg.fst <= sfg_pkg::FLT_RUN;
            st_reg.boot <= 1'b1;
            st_reg.off <= 1'b1;
            st_reg.dim <= 8'hFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign cfg_rdata_out = st_reg.rdata;
    assign stage2_off_out = st_reg.off;
    assign stages_power_en_out = st_reg.started;
    assign fault_active_out = st_reg.fact;
    assign fault_latched_out = st_reg.fst[2];
    assign fault_cause_out = st_reg.cause;
    assign fault_off_behaviour_out = st_reg.regs[sfg_pkg::IX_RETRY][sfg_pkg::B_OFF_BEH];
    assign ntc_code_out = st_reg.code;
    assign external_thermal_guard_out = st_reg.ext_hot;
    assign die_thermal_guard_out = st_reg.die_hot;
    assign dim_scale_out = st_reg.dim;

    // Checks
    a_ov_disable_zero: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $past(dov) && dov |-> st_reg.ov_acc == 3'h0)
        else $error("overvoltage count moved while disabled");
    a_ov_count_up: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(st_reg.gate_q) && $past(st_reg.fst) == sfg_pkg::FLT_RUN && !$past(dov)
        && $past(st_reg.ov_hit) && $past(st_reg.ov_acc) != 3'h7
        |-> st_reg.ov_acc == $past(st_reg.ov_acc) + 3'h1)
        else $error("overvoltage count did not step up");
    a_ov_fault_entry: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        st_reg.fst == sfg_pkg::FLT_RUN && !dov && st_reg.ov_acc >= tov
        |=> st_reg.fact && st_reg.cause[0])
        else $error("overvoltage fault not declared");
    a_latch_holds: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        st_reg.fst == sfg_pkg::FLT_LATCH |=> st_reg.fst == sfg_pkg::FLT_LATCH ##1 st_reg.fact)
        else $error("latched fault released");
    a_oc_count_down: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $fell(st_reg.gate_q) && $past(st_reg.fst) == sfg_pkg::FLT_RUN && !$past(doc)
        && !$past(st_reg.oc_hit) && $past(st_reg.oc_acc) != 3'h0
        |-> st_reg.oc_acc == $past(st_reg.oc_acc) - 3'h1)
        else $error("overcurrent count did not step down");
    a_die_stop: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        st_reg.s2[sfg_pkg::S_DHI] |=> st_reg.die_hot && st_reg.off)
        else $error("die overheat did not stop switching");
    a_code_step: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !st_reg.boot && !half_line_in |=> $stable(st_reg.code))
        else $error("thermistor code moved without half line-cycle");
    a_wait_wake: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !st_reg.started |-> st_reg.off)
        else $error("stage two ran before wake-up check");
    a_restart_clear: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $past(st_reg.fst) == sfg_pkg::FLT_HOLD && st_reg.fst == sfg_pkg::FLT_RUN
        |-> st_reg.ov_acc == 3'h0 && st_reg.oc_acc == 3'h0 && st_reg.ol_acc == 3'h0)
        else $error("counts not cleared on restart");
endmodule
`default_nettype wire

// ===== design/sfg_pkg.sv
package sfg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_SLOPE = 8'h4C;
    localparam logic [7:0] OFS_RESUME = 8'h4E;
    localparam logic [7:0] OFS_DIS = 8'h4F;
    localparam logic [7:0] OFS_BLANK = 8'h50;
    localparam logic [7:0] OFS_CNT = 8'h51;
    localparam logic [7:0] OFS_AUX = 8'h52;
    localparam logic [7:0] OFS_RETRY = 8'h53;
    localparam logic [7:0] OFS_FILT = 8'h57;
    localparam logic [7:0] OFS_CUTOFF = 8'h5A;
    localparam logic [7:0] OFS_DERATE = 8'h5B;
    localparam int NREG = 10;
    localparam logic [NREG-1:0][7:0] REG_OFS = {OFS_DERATE, OFS_CUTOFF, OFS_FILT,
        OFS_RETRY, OFS_AUX, OFS_CNT, OFS_BLANK, OFS_DIS, OFS_RESUME, OFS_SLOPE};
    // Register reset values, index 9 down to 0
    localparam logic [NREG-1:0][7:0] REG_RST = {8'hC4, 8'h0F, 8'h00,
        8'h0F, 8'h70, 8'h3F, 8'h00, 8'h00, 8'h0E, 8'h00};
    // Register indices
    localparam int IX_SLOPE = 0;
    localparam int IX_RESUME = 1;
    localparam int IX_DIS = 2;
    localparam int IX_BLANK = 3;
    localparam int IX_CNT = 4;
    localparam int IX_AUX = 5;
    localparam int IX_RETRY = 6;
    localparam int IX_FILT = 7;
    localparam int IX_CUTOFF = 8;
    localparam int IX_DERATE = 9;
    // Field positions (lsb of each field)
    localparam int B_OV_DIS = 0;
    localparam int B_OC_DIS = 1;
    localparam int B_OL_DIS = 2;
    localparam int F_OC_BLANK = 0;
    localparam int F_OL_BLANK = 3;
    localparam int F_OC_CNT = 0;
    localparam int F_OL_CNT = 3;
    localparam int B_OC_LAT = 6;
    localparam int B_OL_LAT = 7;
    localparam int F_OV_BLANK = 0;
    localparam int B_OV_STYLE = 3;
    localparam int F_OV_CNT = 4;
    localparam int B_OV_LAT = 7;
    localparam int F_RETRY = 0;
    localparam int B_SLOW = 6;
    localparam int B_OFF_BEH = 7;
    localparam int F_FAST_TC = 0;
    localparam int F_SLOW_TC = 3;
    // Timing
    localparam int CLK_NS = 100;
    localparam int BLANK_UNIT_NS = 200;
    localparam int BLANK_UNIT_CYC = (BLANK_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OL_SCAN_NS = 250;
    localparam int OL_SCAN_CYC = (OL_SCAN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRACK_US = 5000;
    localparam int BOOT_STEP_CYC = TRACK_US * 1000 / CLK_NS / 256;
    localparam int FAST_TICK_US = 100;
    localparam int FAST_TICK_CYC = FAST_TICK_US * 1000 / CLK_NS;
    localparam int SLOW_TICK_US = 10000;
    localparam int RETRY_FAST_US = 10000;
    localparam int RETRY_SLOW_US = 100000;
    localparam logic [2:0] HALF_LINE_LAST = 3'h6;
    // Synchroniser bit positions
    localparam int S_OV = 0;
    localparam int S_OC = 1;
    localparam int S_OL = 2;
    localparam int S_NTC = 3;
    localparam int S_DHI = 4;
    localparam int S_DLO = 5;
    // Fault supervisor states
    typedef enum logic [2:0] {
        FLT_RUN = 3'b001,
        FLT_HOLD = 3'b010,
        FLT_LATCH = 3'b100
    } sfg_flt_e;
endpackage

// ===== sim/sfg_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side comparators of the power stage and thermistor pin
module sfg_stage_model (
    // Scenario controls
    input wire logic gate_in,
    input wire logic ov_in,
    input wire logic oc_in,
    input wire logic [7:0] code_in,
    input wire logic open_in,
    input wire logic [7:0] eq_in,
    // Comparator levels
    output logic aux_out,
    output logic cur_out,
    output logic min_out,
    output logic ntc_out
);
    // Aux winding overshoots only in the off phase
    assign aux_out = ov_in & ~gate_in;
    // Sense exceeds its limit only while the gate conducts
    assign cur_out = oc_in & gate_in;
    // Sense reaches its open-loop minimum while the gate conducts, unless the loop is cut
    assign min_out = gate_in & ~open_in;
    // more current, higher pin; a hotter part moves the balance code up
    assign ntc_out = code_in > eq_in;
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rstn = 0, we = 0, gate = 0, ov = 0, oc = 0, dhi = 0, dlo = 0;
    logic hl = 0, opn = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, code, dim, eq = 8'h20;
    logic aux, cur, mn, ntc, off, pen, fa, fl, fob, eg, dg;
    logic [2:0] fc;
    int err_count = 0, tests_run = 0, cyc = 0;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
    sfg_guard #(.RETRY_FAST_CYC(8), .RETRY_SLOW_CYC(16), .SLOW_TICK_CYC(4)) i_sfg_guard (
        .sys_clk_in(clk), .rstn_in(rstn), .cfg_wr_en_in(we), .cfg_addr_in(addr),
        .cfg_wdata_in(wd), .cfg_rdata_out(rd), .stage2_gate_drive_in(gate),
        .aux_winding_feedback_in(aux), .stage2_current_sense_in(cur),
        .stage2_sense_min_in(mn), .ntc_above_ref_in(ntc), .die_over_limit_in(dhi),
        .die_resume_in(dlo), .half_line_in(hl), .stage2_off_out(off),
        .stages_power_en_out(pen), .fault_active_out(fa), .fault_latched_out(fl),
        .fault_cause_out(fc), .fault_off_behaviour_out(fob), .ntc_code_out(code),
        .external_thermal_guard_out(eg), .die_thermal_guard_out(dg), .dim_scale_out(dim));
    sfg_stage_model i_sfg_stage_model (.gate_in(gate), .ov_in(ov), .oc_in(oc),
        .code_in(code), .open_in(opn), .eq_in(eq), .aux_out(aux), .cur_out(cur),
        .min_out(mn), .ntc_out(ntc));
    // Clock and hang guard
    initial forever #50 clk = ~clk;
    // half line-cycle pulse every other clock
    always @(negedge clk) hl <= ~hl;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            summarize();
        end
    end
    task summarize;
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        we = 1;
        @(negedge clk);
        we = 0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        `CHK("register", e, rd)
    endtask
    // Gate pulses of six cycles on, seven off (six after the last)
    task pulse(input int n);
        repeat (n) begin
            @(negedge clk);
            gate = 1;
            repeat (6) @(negedge clk);
            gate = 0;
            repeat (6) @(negedge clk);
        end
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1;
        for (int i = 0; i < sfg_pkg::NREG; i++) rdc(sfg_pkg::REG_OFS[i], sfg_pkg::REG_RST[i]);
        rdc(8'h4D, 8'h00);
        wr(8'h53, 8'h85);
        rdc(8'h53, 8'h85);
        `CHK("behaviour", 1'b1, fob)
        while (pen !== 1'b1 && cyc < 80000) @(negedge clk);
        `CHK("power", 1'b1, pen)
        `CHK("cool", 9'h0FF, {eg, dim})
        wr(8'h5B, 8'h28);
        wr(8'h4E, 8'h03);
        wr(8'h5A, 8'h04);
        wr(8'h4C, 8'h02);
        eq = 8'h80;
        repeat (5000) @(negedge clk);
        `CHK("hot", 3'b111, {eg, off, code[7]})
        `CHK("derate", 8'h00, dim)
        eq = 8'h20;
        repeat (8000) @(negedge clk);
        `CHK("cooled", 10'h0FF, {eg, off, dim})
        dhi = 1;
        repeat (5) @(negedge clk);
        `CHK("die hot", 2'b11, {dg, off})
        dhi = 0;
        dlo = 1;
        repeat (5) @(negedge clk);
        `CHK("die cool", 1'b0, dg)
        dlo = 0;
        wr(8'h4F, 8'h05);
        wr(8'h52, 8'h90);
        ov = 1;
        pulse(3);
        `CHK("ov off", 1'b0, fa)
        wr(8'h51, 8'h02);
        ov = 0;
        oc = 1;
        pulse(1);
        `CHK("oc one", 1'b0, fa)
        pulse(1);
        `CHK("oc fault", 6'h32, {off, fa, fl, fc})
        oc = 0;
        repeat (70) @(negedge clk);
        `CHK("retry", 1'b0, fa)
        wr(8'h51, 8'h12);
        wr(8'h4F, 8'h03);
        opn = 1;
        pulse(1);
        `CHK("ol one", 1'b0, fa)
        pulse(1);
        `CHK("ol fault", 6'h34, {off, fa, fl, fc})
        opn = 0;
        repeat (70) @(negedge clk);
        `CHK("ol retry", 1'b0, fa)
        wr(8'h4F, 8'h06);
        ov = 1;
        pulse(2);
        `CHK("ov fault", 6'h39, {off, fa, fl, fc})
        ov = 0;
        repeat (100) @(negedge clk);
        `CHK("latched", 2'b11, {fa, fl})
        summarize();
    end
endmodule
`default_nettype wire
